// File: core/cmd_ctl_consts.svh
// offsets, field positions and reset values of the pci command control block
`ifndef CMD_CTL_CONSTS_SVH
`define CMD_CTL_CONSTS_SVH
`define CMD_REG_OFFSET 12'h004
`define STS_REG_OFFSET 12'h006
`define CMD_IO_EN_BIT 0
`define CMD_MEM_EN_BIT 1
`define CMD_FWD_EN_BIT 2
`define CMD_POISON_EN_BIT 6
`define CMD_ERR_EN_BIT 8
`define CMD_IRQ_DIS_BIT 10
`define CMD_WRITABLE_MASK 16'h0547
`define CMD_RESET 16'h0000
`define STS_PARITY_BIT 8
`define STS_SYSERR_BIT 14
`define STS_RESET 16'h0000
`endif

// File: core/cmd_ctl_pkg.sv
// types shared by the pci command control block
package cmd_ctl_pkg;
  // kind of a request that the bridge would forward
  typedef enum logic [1:0] {req_mem, req_io, req_msg, req_cfg} req_kind_t;
  // status flag update state
  typedef enum logic {flag_idle, flag_set} flag_state_t;
endpackage

// File: core/sticky_flag.sv
// sticky status flag, hardware sets, software writes one to clear
module sticky_flag
(
  input wire logic clk,
  input wire logic rst,
  input wire logic set_pulse,
  input wire logic clear_pulse,
  output logic flag
);
  logic next_flag;

  // set wins over a clear in the same cycle
  always_comb
  begin
    next_flag = flag;
    if (clear_pulse)
      next_flag = 1'b0;
    if (set_pulse)
      next_flag = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag <= 1'b0;
    else
      flag <= next_flag;
  end
endmodule

// File: core/pci_command_control.sv
// pci command register bits 0..15 with forwarding, error and interrupt gating
`include "cmd_ctl_consts.svh"

// Functional notes
// - forward disabled blocks mem, io requests, not msi
// - forward disabled answers non-posted with UR
// - completions and other requests never blocked
// - unsupported legacy fields always read zero
// - poison enable sets parity flag on poison
// - error enable gates fatal/non-fatal error messages
// - irq disable stops legacy intx, not msi
// - external side never makes intx
// - parity flag status bit 8, write-one clear
// - error message sent sets system error flag
module pci_command_control
  import cmd_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // configuration access port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [1:0] cfg_be,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  // request forwarding check
  input wire logic req_valid,
  input wire req_kind_t req_kind,
  input wire logic req_is_completion,
  input wire logic req_non_posted,
  output logic req_forward,
  output logic req_reject_ur,
  // poison and error events
  input wire logic poisoned_cpl_rx,
  input wire logic poisoned_wr_tx,
  input wire logic fatal_err_detect,
  input wire logic nonfatal_err_detect,
  output logic err_fatal_msg,
  output logic err_nonfatal_msg,
  // interrupt generation
  input wire logic intx_request,
  input wire logic msi_request,
  input wire logic side_external,
  output logic intx_msg,
  output logic msi_msg,
  // control levels to the rest of the bridge
  output logic request_forward_enable,
  output logic poison_report_enable,
  output logic error_report_enable,
  output logic legacy_irq_disable,
  output logic master_parity_error_flag,
  output logic system_error_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // command register
  logic [15:0] cmd;
  logic [15:0] next_cmd;
  logic cmd_hit;
  logic sts_hit;

  assign cmd_hit = (cfg_addr == `CMD_REG_OFFSET);
  assign sts_hit = (cfg_addr == `STS_REG_OFFSET);

  // merge a byte-enabled write under the writable mask
  function automatic logic [15:0] merge_write(input logic [15:0] old_v,
    input logic [15:0] new_v, input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge_write = (old_v & ~lanes) | (new_v & lanes);
  endfunction

  // only writable bits ever change, fixed fields stay zero
  always_comb
  begin
    next_cmd = cmd;
    if (cfg_wr && cmd_hit)
      next_cmd = merge_write(cmd, cfg_wdata, cfg_be, `CMD_WRITABLE_MASK);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cmd <= `CMD_RESET;
    else
      cmd <= next_cmd;
  end

  assign request_forward_enable = cmd[`CMD_FWD_EN_BIT];
  assign poison_report_enable = cmd[`CMD_POISON_EN_BIT];
  assign error_report_enable = cmd[`CMD_ERR_EN_BIT];
  assign legacy_irq_disable = cmd[`CMD_IRQ_DIS_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // request gating, combinational handshake
  logic blockable;

  // completions and message or config requests pass regardless
  assign blockable = !req_is_completion && (req_kind == req_mem || req_kind == req_io);
  assign req_forward = req_valid && (request_forward_enable || !blockable);
  assign req_reject_ur = req_valid && !request_forward_enable && blockable
    && req_non_posted;

  ////////////////////////////////////////////////////////////////////////////
  // error messages and status flags
  logic parity_set;
  logic syserr_set;
  logic [1:0] w1c_lanes;

  assign parity_set = poison_report_enable && (poisoned_cpl_rx || poisoned_wr_tx);
  assign w1c_lanes = (cfg_wr && sts_hit) ? cfg_be : 2'b00;

  // messages registered so data outputs come from flip-flops
  logic next_fatal;
  logic next_nonfatal;
  always_comb
  begin
    next_fatal = fatal_err_detect && error_report_enable;
    next_nonfatal = nonfatal_err_detect && error_report_enable;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      err_fatal_msg <= 1'b0;
      err_nonfatal_msg <= 1'b0;
    end
    else
    begin
      err_fatal_msg <= next_fatal;
      err_nonfatal_msg <= next_nonfatal;
    end
  end

  // flag set by the message actually sent, two cycles after detection
  assign syserr_set = err_fatal_msg || err_nonfatal_msg;

  sticky_flag parity_flag_i
  (
    .clk(clk),
    .rst(rst),
    .set_pulse(parity_set),
    .clear_pulse(w1c_lanes[1] && cfg_wdata[`STS_PARITY_BIT]),
    .flag(master_parity_error_flag)
  );

  sticky_flag syserr_flag_i
  (
    .clk(clk),
    .rst(rst),
    .set_pulse(syserr_set),
    .clear_pulse(w1c_lanes[1] && cfg_wdata[`STS_SYSERR_BIT]),
    .flag(system_error_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt messages; external side never raises intx at all
  logic next_intx;
  logic next_msi;
  always_comb
  begin
    next_intx = intx_request && !legacy_irq_disable && !side_external;
    next_msi = msi_request;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      intx_msg <= 1'b0;
      msi_msg <= 1'b0;
    end
    else
    begin
      intx_msg <= next_intx;
      msi_msg <= next_msi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered; other offsets read zero
  logic [15:0] next_rdata;
  always_comb
  begin
    next_rdata = 16'h0000;
    if (cfg_rd && cmd_hit)
      next_rdata = cmd & `CMD_WRITABLE_MASK;
    else if (cfg_rd && sts_hit)
    begin
      next_rdata[`STS_PARITY_BIT] = master_parity_error_flag;
      next_rdata[`STS_SYSERR_BIT] = system_error_flag;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cfg_rdata <= 16'h0000;
    else
      cfg_rdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  fwd_block_a: assert property (@(posedge clk) disable iff (rst)
    (req_valid && !request_forward_enable && blockable) |-> !req_forward)
    else $error("blocked request forwarded");
  ur_answer_a: assert property (@(posedge clk) disable iff (rst)
    (req_valid && !cmd[2] && !req_is_completion && req_kind == req_io && req_non_posted)
    |-> req_reject_ur)
    else $error("non-posted io not rejected");
  cpl_pass_a: assert property (@(posedge clk) disable iff (rst)
    (req_valid && req_is_completion) |-> (req_forward && !req_reject_ur))
    else $error("completion blocked");
  fixed_zero_a: assert property (@(posedge clk) disable iff (rst)
    (cmd[5:3] == 3'b000) && (cmd[7] == 1'b0) && (cmd[9] == 1'b0))
    else $error("unsupported field nonzero");
  poison_set_a: assert property (@(posedge clk) disable iff (rst)
    (poison_report_enable && (poisoned_cpl_rx || poisoned_wr_tx))
    |=> master_parity_error_flag)
    else $error("parity flag not set");
  poison_off_a: assert property (@(posedge clk) disable iff (rst)
    (!master_parity_error_flag && !poison_report_enable) |=> !master_parity_error_flag)
    else $error("parity flag set while disabled");
  err_gate_a: assert property (@(posedge clk) disable iff (rst)
    ((fatal_err_detect || nonfatal_err_detect) && !error_report_enable)
    |=> !(err_fatal_msg || err_nonfatal_msg))
    else $error("error reported while disabled");
  syserr_set_a: assert property (@(posedge clk) disable iff (rst)
    ((fatal_err_detect || nonfatal_err_detect) && error_report_enable)
    |=> ##1 system_error_flag)
    else $error("system error flag not set");
  w1c_clear_a: assert property (@(posedge clk) disable iff (rst)
    (cfg_wr && sts_hit && cfg_be[1] && cfg_wdata[8] && !parity_set)
    |=> !master_parity_error_flag)
    else $error("parity flag not cleared");
  reserved_a: assert property (@(posedge clk) disable iff (rst)
    $past(cfg_rd) |-> (cfg_rdata[15:11] == 5'b00000 || $past(sts_hit)))
    else $error("reserved bits nonzero");
  intx_gate_a: assert property (@(posedge clk) disable iff (rst)
    (intx_request && legacy_irq_disable) |=> !intx_msg)
    else $error("intx while disabled");
  ext_intx_a: assert property (@(posedge clk) disable iff (rst)
    side_external |=> !intx_msg)
    else $error("intx from external side");
  msi_pass_a: assert property (@(posedge clk) disable iff (rst)
    msi_request |=> msi_msg)
    else $error("msi suppressed");

  fwd_ur_c: cover property (@(posedge clk) disable iff (rst) req_reject_ur);
  parity_c: cover property (@(posedge clk) disable iff (rst) parity_set);
  syserr_c: cover property (@(posedge clk) disable iff (rst) system_error_flag);
  intx_c: cover property (@(posedge clk) disable iff (rst) intx_msg);
endmodule

// File: verif/cfg_host_model.sv
// root complex model issuing configuration reads and writes
module cfg_host_model
(
  input wire logic clk,
  input wire logic [15:0] cfg_rdata,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [11:0] cfg_addr,
  output logic [1:0] cfg_be,
  output logic [15:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle values; address parked off the map so a stale one never matches
  initial
  begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 12'hfff;
    cfg_be = 2'b00;
    cfg_wdata = 16'h0000;
  end
  // one strobe, held across a single edge, then bus inverted
  task automatic wr(input logic [11:0] a, input logic [1:0] be, input logic [15:0] d);
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d; // ones clear status flags
    cfg_wr = 1'b1;
    @(posedge clk);
    #1;
    cfg_wr = 1'b0;
    cfg_addr = ~a;
    cfg_wdata = ~d;
    // idle cycle, so a following access never reassigns the bus in this step
    @(posedge clk);
    #1;
  endtask
  // data is taken in the cycle after the strobe edge, it stands one cycle only
  task automatic rd(input logic [11:0] a, output logic [15:0] q);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(posedge clk);
    #1;
    cfg_rd = 1'b0;
    cfg_addr = ~a;
    q = cfg_rdata;
    @(posedge clk);
    #1;
  endtask
endmodule

// File: verif/pci_command_control_tb.sv
// self-checking bench for the pci command control block
`include "cmd_ctl_consts.svh"
module pci_command_control_tb
  import cmd_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, cfg_wr, cfg_rd, req_valid, req_is_completion, req_non_posted;
  logic [11:0] cfg_addr;
  logic [1:0] cfg_be;
  logic [15:0] cfg_wdata, cfg_rdata;
  req_kind_t req_kind;
  logic req_forward, req_reject_ur, poisoned_cpl_rx, poisoned_wr_tx;
  logic fatal_err_detect, nonfatal_err_detect, err_fatal_msg, err_nonfatal_msg;
  logic intx_request, msi_request, side_external, intx_msg, msi_msg;
  logic request_forward_enable, poison_report_enable, error_report_enable;
  logic legacy_irq_disable, master_parity_error_flag, system_error_flag;
  int n_fail = 0;
  int total_checks = 0;
  pci_command_control i_pci_command_control (.clk, .rst, .cfg_wr, .cfg_rd, .cfg_addr,
    .cfg_be, .cfg_wdata, .cfg_rdata, .req_valid, .req_kind, .req_is_completion,
    .req_non_posted, .req_forward, .req_reject_ur, .poisoned_cpl_rx, .poisoned_wr_tx,
    .fatal_err_detect, .nonfatal_err_detect, .err_fatal_msg, .err_nonfatal_msg,
    .intx_request, .msi_request, .side_external, .intx_msg, .msi_msg,
    .request_forward_enable, .poison_report_enable, .error_report_enable,
    .legacy_irq_disable, .master_parity_error_flag, .system_error_flag);
  cfg_host_model i_cfg_host_model (.clk, .cfg_rdata, .cfg_wr, .cfg_rd, .cfg_addr,
    .cfg_be, .cfg_wdata);
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [15:0] e);
    logic [15:0] q;
    i_cfg_host_model.rd(a, q);
    chk(q, e);
  endtask
  // combinational verdict, looked at in the same cycle
  task automatic fwd(input req_kind_t k, input logic c, np, input logic [1:0] e);
    req_kind = k;
    req_is_completion = c;
    req_non_posted = np;
    #1;
    chk({req_forward, req_reject_ur}, e);
    step;
  endtask
  // one-cycle event pulses: cpl poison, wr poison, fatal, nonfatal, intx, msi
  task automatic ev(input logic [5:0] v);
    step; // idle cycle keeps back-to-back pulses apart
    {poisoned_cpl_rx, poisoned_wr_tx, fatal_err_detect, nonfatal_err_detect} = v[5:2];
    {intx_request, msi_request} = v[1:0];
    step;
    {poisoned_cpl_rx, poisoned_wr_tx, fatal_err_detect, nonfatal_err_detect} = 4'h0;
    {intx_request, msi_request} = 2'b00;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // watchdog, the whole sequence needs well under a microsecond
  initial
  begin
    #20000;
    n_fail++;
    test_done;
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b1;
    side_external = 1'b0;
    req_kind = req_msg;
    req_is_completion = 1'b0;
    req_non_posted = 1'b0;
    // ev takes two edges, so reset spans ten edges in all
    ev(6'h00);
    repeat (8) step;
    rst = 1'b0;
    rc(`CMD_REG_OFFSET, 16'h0000);
    rc(`STS_REG_OFFSET, 16'h0000);
    rc(12'h008, 16'h0000);
    $display("reset values done");
    fwd(req_mem, 1'b0, 1'b1, 2'b01);
    fwd(req_io, 1'b0, 1'b1, 2'b01);
    fwd(req_mem, 1'b0, 1'b0, 2'b00);
    fwd(req_cfg, 1'b0, 1'b1, 2'b10);
    fwd(req_mem, 1'b1, 1'b0, 2'b10);
    i_cfg_host_model.wr(`CMD_REG_OFFSET, 2'b11, 16'hffff);
    rc(`CMD_REG_OFFSET, 16'h0547);
    chk({request_forward_enable, poison_report_enable, error_report_enable,
      legacy_irq_disable}, 4'hf);
    fwd(req_mem, 1'b0, 1'b1, 2'b10);
    $display("forwarding done");
    // low byte only: poison reporting off, error and irq-disable kept
    i_cfg_host_model.wr(`CMD_REG_OFFSET, 2'b01, 16'hff00);
    rc(`CMD_REG_OFFSET, 16'h0500);
    chk({request_forward_enable, poison_report_enable, error_report_enable,
      legacy_irq_disable}, 4'h3);
    ev(6'h20);
    chk(master_parity_error_flag, 1'b0);
    ev(6'h08);
    chk(err_fatal_msg, 1'b1);
    step;
    chk(system_error_flag, 1'b1);
    ev(6'h03);
    chk({intx_msg, msi_msg}, 2'b01);
    i_cfg_host_model.wr(`CMD_REG_OFFSET, 2'b11, 16'h0044);
    ev(6'h10);
    chk(master_parity_error_flag, 1'b1);
    ev(6'h04);
    chk(err_nonfatal_msg, 1'b0);
    ev(6'h02);
    chk(intx_msg, 1'b1);
    side_external = 1'b1;
    ev(6'h02);
    chk(intx_msg, 1'b0);
    rc(`STS_REG_OFFSET, 16'h4100);
    i_cfg_host_model.wr(`STS_REG_OFFSET, 2'b11, 16'h4100);
    rc(`STS_REG_OFFSET, 16'h0000);
    $display("events done");
    test_done;
  end
endmodule
